// [design/pfd_pkg.sv]
// package for the protection fet drive control block
package pfd_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_HOSTCMD = 8'h04;
  localparam logic [7:0] REG_FAULT = 8'h08;
  localparam logic [7:0] REG_INTSTAT = 8'h0C;
  localparam logic [7:0] REG_INTMASK = 8'h10;
  localparam logic [7:0] REG_CHGTHR = 8'h14;
  localparam logic [7:0] REG_DSGTHR = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;
  // config field positions
  localparam int CFG_SFOLLOW = 0;
  localparam int CFG_OVD_HI = 1;
  localparam int CFG_PARALLEL = 2;
  localparam int CFG_MODE_LO = 3;
  localparam int CFG_CHG_PRESENT = 5;
  localparam int CFG_DSG_PRESENT = 6;
  localparam int CFG_WIDTH = 7;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 7'h60;
  // host command bits
  localparam int CMD_CHG_OFF = 0;
  localparam int CMD_DSG_OFF = 1;
  // interrupt status bits
  localparam int IRQ_CHG_FAULT = 0;
  localparam int IRQ_DSG_FAULT = 1;
  localparam int IRQ_WIDTH = 2;
  // current thresholds, signed, reset values
  localparam int CUR_WIDTH = 16;
  localparam logic [CUR_WIDTH-1:0] CHGTHR_RESET = 16'h0064;
  localparam logic [CUR_WIDTH-1:0] DSGTHR_RESET = 16'hFF9C;
  // control modes
  typedef enum logic [1:0] {
    PFD_AUTO,
    PFD_PARTIAL,
    PFD_MANUAL
  } pfd_mode_t;
endpackage

// [design/pfd_fet_ctrl.sv]
// protection fet drive control with wishbone register slave
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pfd_fet_ctrl
  import pfd_pkg::*;
#(
  parameter int CurWidth = CUR_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // protection subsystem
  input wire logic chargeFault,
  input wire logic dischargeFault,
  input wire logic sleepMode,
  input wire logic signed [CurWidth-1:0] packCurrent,
  input wire logic prechargeFetOn,
  input wire logic predischargeFetOn,
  // host pins
  input wire logic chargeFetBlockPin,
  input wire logic dischargeFetBlockPin,
  output logic alertIrq,
  // fet drive
  output logic chargeFet,
  output logic dischargeFet,
  output logic dischargeFromBattery,
  output logic pumpOverdriveHigh
);

  // ==========================================================
  // registers
  logic [CFG_WIDTH-1:0] cfgReg;
  logic [1:0] hostCmd;
  logic [IRQ_WIDTH-1:0] intStat;
  logic [IRQ_WIDTH-1:0] intMask;
  logic [CurWidth-1:0] chgThr;
  logic [CurWidth-1:0] dsgThr;
  logic [1:0] faultLatch;
  logic faultPrevC;
  logic faultPrevD;

  logic wbReq;
  logic wbWr;
  logic [31:0] next_rdata;
  pfd_mode_t mode;

  function automatic logic [31:0] mask_write(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // signed current compares, shared by body diode and drive source logic
  function automatic logic cur_below(input logic [CurWidth-1:0] cur,
                                     input logic [CurWidth-1:0] thr);
    return $signed(cur) < $signed(thr);
  endfunction

  function automatic logic cur_above(input logic [CurWidth-1:0] cur,
                                     input logic [CurWidth-1:0] thr);
    return $signed(cur) > $signed(thr);
  endfunction

  // full-word images of each byte-lane write; the registers keep only their low bits
  logic [31:0] cfgWord;
  logic [31:0] cmdWord;
  logic [31:0] maskWord;
  logic [31:0] chgThrWord;
  logic [31:0] dsgThrWord;

  assign cfgWord = mask_write(32'(cfgReg), wb_dat_i, wb_sel_i);
  assign cmdWord = mask_write(32'(hostCmd), wb_dat_i, wb_sel_i);
  assign maskWord = mask_write(32'(intMask), wb_dat_i, wb_sel_i);
  assign chgThrWord = mask_write(32'(chgThr), wb_dat_i, wb_sel_i);
  assign dsgThrWord = mask_write(32'(dsgThr), wb_dat_i, wb_sel_i);

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWr = wbReq && wb_we_i;

  always_comb
  begin
    case (cfgReg[CFG_MODE_LO +: 2])
      2'h1: mode = PFD_PARTIAL;
      2'h2: mode = PFD_MANUAL;
      default: mode = PFD_AUTO;
    endcase
  end

  // ==========================================================
  // wishbone slave: one wait state, zero data on unmapped reads
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wbReq;
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == REG_CONFIG)
    begin
      next_rdata[CFG_WIDTH-1:0] = cfgReg;
    end
    else if (wb_adr_i == REG_HOSTCMD)
    begin
      next_rdata[1:0] = hostCmd;
    end
    else if (wb_adr_i == REG_FAULT)
    begin
      next_rdata[1:0] = faultLatch;
    end
    else if (wb_adr_i == REG_INTSTAT)
    begin
      next_rdata[IRQ_WIDTH-1:0] = intStat;
    end
    else if (wb_adr_i == REG_INTMASK)
    begin
      next_rdata[IRQ_WIDTH-1:0] = intMask;
    end
    else if (wb_adr_i == REG_CHGTHR)
    begin
      next_rdata[CurWidth-1:0] = chgThr;
    end
    else if (wb_adr_i == REG_DSGTHR)
    begin
      next_rdata[CurWidth-1:0] = dsgThr;
    end
    else if (wb_adr_i == REG_STATE)
    begin
      next_rdata[3:0] = {pumpOverdriveHigh, dischargeFromBattery, dischargeFet, chargeFet};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (wbReq && !wb_we_i)
    begin
      wb_dat_o <= next_rdata;
    end
  end

  // config is the only source of the drive options
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfgReg <= CFG_RESET;
    end
    else if (wbWr && wb_adr_i == REG_CONFIG)
    begin
      cfgReg <= cfgWord[CFG_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hostCmd <= 2'h0;
    end
    else if (wbWr && wb_adr_i == REG_HOSTCMD)
    begin
      hostCmd <= cmdWord[1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      intMask <= '0;
      chgThr <= CHGTHR_RESET;
      dsgThr <= DSGTHR_RESET;
    end
    else if (wbWr)
    begin
      if (wb_adr_i == REG_INTMASK)
      begin
        intMask <= maskWord[IRQ_WIDTH-1:0];
      end
      else if (wb_adr_i == REG_CHGTHR)
      begin
        chgThr <= chgThrWord[CurWidth-1:0];
      end
      else if (wb_adr_i == REG_DSGTHR)
      begin
        dsgThr <= dsgThrWord[CurWidth-1:0];
      end
    end
  end

  // ==========================================================
  // fault latch and interrupt
  logic [IRQ_WIDTH-1:0] faultRise;
  logic [IRQ_WIDTH-1:0] w1c;
  logic [1:0] faultNow;

  assign faultNow = {dischargeFault, chargeFault};
  assign faultRise = {dischargeFault && !faultPrevD, chargeFault && !faultPrevC};
  assign w1c = (wbWr && wb_adr_i == REG_INTSTAT && wb_sel_i[0]) ? wb_dat_i[IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      faultPrevC <= 1'b0;
      faultPrevD <= 1'b0;
    end
    else
    begin
      faultPrevC <= chargeFault;
      faultPrevD <= dischargeFault;
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      intStat <= '0;
    end
    else
    begin
      intStat <= (intStat & ~w1c) | faultRise;
    end
  end

  // outside autonomous mode a fault stays latched until the host clears it by a fault write
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      faultLatch <= 2'h0;
    end
    else if (mode == PFD_AUTO)
    begin
      faultLatch <= faultNow;
    end
    else
    begin
      faultLatch <= faultNow |
        (faultLatch & ~((wbWr && wb_adr_i == REG_FAULT) ? wb_dat_i[1:0] : 2'h0));
    end
  end

  assign alertIrq = |(intStat & intMask);

  // ==========================================================
  // fet decision
  logic chgInhibit;
  logic dsgInhibit;
  logic chgWanted;
  logic dsgWanted;
  logic chgBodyDiode;
  logic dsgBodyDiode;
  logic seriesMode;
  logic dischargeSeen;

  assign seriesMode = !cfgReg[CFG_PARALLEL];

  // the manual mode host does not rely on autonomous turn-off: faults only flag
  assign chgInhibit = !cfgReg[CFG_CHG_PRESENT] ||
    ((mode != PFD_MANUAL) && faultLatch[0]) ||
    hostCmd[CMD_CHG_OFF] || chargeFetBlockPin;
  assign dsgInhibit = !cfgReg[CFG_DSG_PRESENT] ||
    ((mode != PFD_MANUAL) && faultLatch[1]) ||
    hostCmd[CMD_DSG_OFF] || dischargeFetBlockPin;

  // current below the discharge threshold means significant discharge current
  assign dischargeSeen = cur_below(packCurrent, dsgThr);

  // body diode protection never overrides a missing fet or a block pin, but it does
  // override faults and host commands, since the body diode would otherwise carry it
  assign chgBodyDiode = seriesMode && cfgReg[CFG_CHG_PRESENT] && !chargeFetBlockPin &&
    (!dsgInhibit || predischargeFetOn) &&
    dischargeSeen;
  assign dsgBodyDiode = seriesMode && cfgReg[CFG_DSG_PRESENT] && !dischargeFetBlockPin &&
    (!chgInhibit || prechargeFetOn) &&
    cur_above(packCurrent, chgThr);

  assign chgWanted = !chgInhibit || chgBodyDiode;
  assign dsgWanted = !dsgInhibit || dsgBodyDiode;

  // ==========================================================
  // fet enables follow the decision one edge later
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      chargeFet <= 1'b0;
      dischargeFet <= 1'b0;
    end
    else
    begin
      chargeFet <= chgWanted;
      dischargeFet <= dsgWanted;
    end
  end

  // battery-sourced drive only in sleep and with no current below dsgThr; a current below
  // dsgThr hands the gate back to the pump, so the pump must stay charged
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dischargeFromBattery <= 1'b0;
    end
    else
    begin
      dischargeFromBattery <= dsgWanted && cfgReg[CFG_SFOLLOW] && sleepMode &&
        !dischargeSeen;
    end
  end

  // overdrive level is a registered copy of the config bit
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pumpOverdriveHigh <= 1'b0;
    end
    else
    begin
      pumpOverdriveHigh <= cfgReg[CFG_OVD_HI];
    end
  end

endmodule // pfd_fet_ctrl
`default_nettype wire

// [test/pfd_host_model.sv]
// host model driving the two fet block pins
`timescale 1ns/1ns
`default_nettype none
module pfd_host_model (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic [1:0] blockReq,
  // pins to the block
  output logic chargeFetBlockPin,
  output logic dischargeFetBlockPin
);
  // pins move just after an edge, as a port register would
  always_ff @(posedge clk)
  begin
    chargeFetBlockPin <= blockReq[0];
    dischargeFetBlockPin <= blockReq[1];
  end
endmodule // pfd_host_model
`default_nettype wire

// [test/pfd_fet_ctrl_asserts.sv]
// assertions on the fet drive control ports
`timescale 1ns/1ns
`default_nettype none
module pfd_fet_ctrl_asserts (
  // clock and bus
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  // pins and drive
  input wire logic sleepMode,
  input wire logic chargeFetBlockPin,
  input wire logic dischargeFetBlockPin,
  input wire logic chargeFet,
  input wire logic dischargeFet,
  input wire logic dischargeFromBattery,
  input wire logic pumpOverdriveHigh
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence wbReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_resp_a: assert property (wbReq |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chg_block_a: assert property (chargeFetBlockPin |=> !chargeFet) else $error("chg on");
  dsg_block_a: assert property (dischargeFetBlockPin |=> !dischargeFet) else $error("dsg on");
  sf_sleep_a: assert property (!sleepMode |=> !dischargeFromBattery) else $error("sf awake");
  rst_fets_a: assert property ($fell(srst) |-> !chargeFet && !dischargeFet && !wb_ack_o)
    else $error("outputs not reset");
  ovd_cfg_a: assert property ($changed(pumpOverdriveHigh) |->
    $past(wb_cyc_i && wb_stb_i && wb_we_i, 2) || $past(srst, 2)) else $error("ovd moved");
endmodule // pfd_fet_ctrl_asserts
bind pfd_fet_ctrl pfd_fet_ctrl_asserts chk_i (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_ack_o, .sleepMode, .chargeFetBlockPin, .dischargeFetBlockPin, .chargeFet,
  .dischargeFet, .dischargeFromBattery, .pumpOverdriveHigh);
`default_nettype wire

// [test/pfd_fet_ctrl_tb.sv]
// self-checking bench for the fet drive control block
`timescale 1ns/1ns
`default_nettype none
module pfd_fet_ctrl_tb;
  import pfd_pkg::*;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic cf = 1'b0, df = 1'b0, slp = 1'b0, pcOn = 1'b0, pdOn = 1'b0;
  logic ack, irq, cPin, dPin, cFet, dFet, battery_supply_pin, ovd;
  logic [1:0] blk = 2'h0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [15:0] cur = 16'h0000;
  logic [31:0] dat = 32'h0, rd, rdat, seed = 32'hDA79074F;
  int mismatches = 0, n_compared = 0, i;
  // reference model state, kept as integers from the rules
  int mCfg = 'h60, mCmd = 0, mChgThr = 100, mDsgThr = -100;
  int mStat = 0, mMask = 0, mLatC = 0, mLatD = 0;
  always #5 clk = ~clk;
  pfd_host_model host (.clk(clk), .blockReq(blk), .chargeFetBlockPin(cPin),
    .dischargeFetBlockPin(dPin));
  pfd_fet_ctrl uut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .chargeFault(cf), .dischargeFault(df), .sleepMode(slp), .packCurrent(cur),
    .prechargeFetOn(pcOn), .predischargeFetOn(pdOn), .chargeFetBlockPin(cPin),
    .dischargeFetBlockPin(dPin), .alertIrq(irq), .chargeFet(cFet), .dischargeFet(dFet),
    .dischargeFromBattery(battery_supply_pin), .pumpOverdriveHigh(ovd));
  // =====
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // any blocker: absent fet, fault outside manual mode, host command, block pin
  function automatic logic m_inh(input int k);
    int mode;
    int lat;
    mode = (mCfg >> 3) & 3;
    lat = (k == 0) ? mLatC : mLatD;
    return !mCfg[5 + k] || (mode != 2 && lat != 0) || mCmd[k] || blk[k];
  endfunction
  // body diode turn-on only in series, with the fet present and its pin released
  function automatic logic m_fet(input int k);
    int c;
    logic bd;
    c = $signed(cur);
    bd = (k == 0) ? (c < mDsgThr) : (c > mChgThr);
    return !m_inh(k) || (!mCfg[2] && mCfg[5 + k] && !blk[k] &&
      (!m_inh(1 - k) || ((k == 0) ? pdOn : pcOn)) && bd);
  endfunction
  task automatic chk_bus(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_pin(input string s, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic chk_all();
    chk_pin("model chgFet", m_fet(0), cFet);
    chk_pin("model dsgFet", m_fet(1), dFet);
    chk_pin("model fromBat", m_fet(1) && mCfg[0] && slp && $signed(cur) >= mDsgThr, battery_supply_pin);
    chk_pin("model ovd", mCfg[1], ovd);
    chk_pin("model irq", (mStat & mMask) != 0, irq);
  endtask
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (w && a == REG_CONFIG && s[0])
      mCfg = d[6:0];
    if (w && a == REG_HOSTCMD && s[0])
      mCmd = d[1:0];
    if (w && a == REG_INTSTAT && s[0])
      mStat = mStat & ~int'(d[1:0]);
    if (w && a == REG_INTMASK && s[0])
      mMask = d[1:0];
  endtask
  // pins go through the host model, so three edges cover both hops
  task automatic st(input logic [1:0] b, input logic c, d, s, input logic [15:0] u);
    @(posedge clk);
    blk <= b;
    cf <= c;
    df <= d;
    slp <= s;
    cur <= u;
    if (c && !cf)
      mStat = mStat | 1;
    if (d && !df)
      mStat = mStat | 2;
    if (((mCfg >> 3) & 3) == 1 || ((mCfg >> 3) & 3) == 2)
    begin
      mLatC = mLatC | c;
      mLatD = mLatD | d;
    end
    else
    begin
      mLatC = c;
      mLatD = d;
    end
    repeat (3) @(posedge clk);
    blk = b;
    chk_all();
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // =====
  // scenarios
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    wbx(1'b0, REG_CONFIG, 32'h0, 4'hF);
    chk_bus("config", 32'(mCfg), rd);
    wbx(1'b0, REG_CHGTHR, 32'h0, 4'hF);
    chk_bus("chgThr", 32'(mChgThr), rd);
    wbx(1'b0, 8'h20, 32'h0, 4'hF);
    chk_bus("unmapped", 32'h0, rd);
    wbx(1'b1, REG_CONFIG, 32'h7F, 4'h0);
    wbx(1'b0, REG_CONFIG, 32'h0, 4'hF);
    chk_bus("selNone", 32'(mCfg), rd);
    for (i = 0; i < 40; i++)
    begin
      void'(xs());
      st(seed[1:0], seed[2], seed[3], 1'b0, 16'h0000);
      chk_pin("chgFet", !(seed[0] | seed[2]), cFet);
      chk_pin("dsgFet", !(seed[1] | seed[3]), dFet);
    end
    st(2'h0, 1'b0, 1'b0, 1'b0, 16'h0000);
    wbx(1'b1, REG_INTSTAT, 32'h3, 4'hF);
    wbx(1'b1, REG_INTMASK, 32'h1, 4'hF);
    st(2'h0, 1'b1, 1'b1, 1'b0, 16'h0000);
    chk_pin("irq", 1'b1, irq);
    wbx(1'b0, REG_INTSTAT, 32'h0, 4'hF);
    chk_bus("intstat", 32'h3, rd);
    wbx(1'b1, REG_INTSTAT, 32'h1, 4'hF);
    @(posedge clk);
    chk_pin("irqMasked", 1'b0, irq);
    st(2'h0, 1'b0, 1'b1, 1'b0, 16'h00C8);
    chk_pin("bdDsgOn", 1'b1, dFet);
    st(2'h0, 1'b0, 1'b1, 1'b0, 16'h0032);
    chk_pin("bdDsgOff", 1'b0, dFet);
    st(2'h0, 1'b1, 1'b0, 1'b0, 16'hFF38);
    chk_pin("bdChgOn", 1'b1, cFet);
    st(2'h0, 1'b1, 1'b0, 1'b0, 16'hFFCE);
    chk_pin("bdChgOff", 1'b0, cFet);
    pdOn <= 1'b1;
    st(2'h0, 1'b1, 1'b1, 1'b0, 16'hFF38);
    chk_pin("bdPredsg", 1'b1, cFet);
    pdOn <= 1'b0;
    wbx(1'b1, REG_CONFIG, 32'h64, 4'hF);
    st(2'h0, 1'b1, 1'b0, 1'b0, 16'hFF38);
    chk_pin("bdParallel", 1'b0, cFet);
    wbx(1'b1, REG_CONFIG, 32'h63, 4'hF);
    st(2'h0, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk_pin("fromBat", 1'b1, battery_supply_pin);
    chk_pin("ovd", 1'b1, ovd);
    wbx(1'b0, REG_STATE, 32'h0, 4'hF);
    chk_bus("state", 32'(4'hF), rd);
    st(2'h0, 1'b0, 1'b0, 1'b1, 16'hFF38);
    chk_pin("toPump", 1'b0, battery_supply_pin);
    wbx(1'b1, REG_CONFIG, 32'h62, 4'hF);
    st(2'h0, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk_pin("sfOff", 1'b0, battery_supply_pin);
    wbx(1'b1, REG_CONFIG, 32'h40, 4'hF);
    st(2'h0, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk_pin("absent", 1'b0, cFet);
    wbx(1'b1, REG_CONFIG, 32'h68, 4'hF);
    wbx(1'b1, REG_HOSTCMD, 32'h1, 4'hF);
    st(2'h0, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk_pin("hostHold", 1'b0, cFet);
    wbx(1'b1, REG_HOSTCMD, 32'h0, 4'hF);
    st(2'h0, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk_pin("hostFree", 1'b1, cFet);
    wbx(1'b1, REG_CONFIG, 32'h70, 4'hF);
    st(2'h0, 1'b1, 1'b0, 1'b0, 16'h0000);
    chk_pin("manFault", 1'b1, cFet);
    wbx(1'b0, REG_FAULT, 32'h0, 4'hF);
    chk_bus("faultRd", 32'h1, rd);
    end_sim();
  end
  // hang guard
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule // pfd_fet_ctrl_tb
`default_nettype wire
